// >>> sgcr_pkg.sv
// Constants and types shared by the global switch control register bank
package sgcr_pkg;

   // Register byte offsets; the frame length and provider tag registers also answer at offset + 1 for the high byte
   localparam logic [11:0] SGCR_MAX_FRAME_LENGTH_OFS = 12'h308;
   localparam logic [11:0] SGCR_PROVIDER_TAG_OFS     = 12'h30a;
   localparam logic [11:0] SGCR_SHAPER_STRATEGY_OFS  = 12'h30e;
   localparam logic [11:0] SGCR_LOOKUP_CTRL0_OFS     = 12'h310;

   // Reset values
   localparam logic [15:0] SGCR_MAX_FRAME_LENGTH_RST = 16'h07d0;
   localparam logic [15:0] SGCR_PROVIDER_TAG_RST     = 16'h9100;
   localparam logic [15:0] SGCR_SHAPER_STRATEGY_RST  = 16'h0001;
   localparam logic [7:0]  SGCR_LOOKUP_CTRL0_RST     = 8'h61;

   // Field positions
   localparam int SGCR_MAX_LEN_MSB        = 13;
   localparam int SGCR_SHAPE_ACCT_BIT     = 1;
   localparam int SGCR_POLICE_ACCT_BIT    = 0;
   localparam int SGCR_VLAN_EN_BIT        = 7;
   localparam int SGCR_DROP_INVALID_BIT   = 6;
   localparam int SGCR_AGE_MSB            = 5;
   localparam int SGCR_AGE_LSB            = 3;
   localparam int SGCR_RSVD_MCAST_BIT     = 2;
   localparam int SGCR_HASH_MSB           = 1;
   localparam int SGCR_HASH_LSB           = 0;

   // Writable bits of the shaper strategy register
   localparam logic [15:0] SGCR_SHAPER_STRATEGY_MASK = 16'h0003;

   // Largest payload length software may program for jumbo frames
   localparam logic [13:0] SGCR_JUMBO_MAX_LEN = 14'h2328;

   // Inter-packet gap plus preamble, in bytes, added when overhead is charged
   localparam logic [15:0] SGCR_IPG_PREAMBLE_BYTES = 16'h0014;

   // Dynamic table index width and CRC generator for the CRC hash
   localparam int          SGCR_INDEX_W  = 10;
   localparam logic [9:0]  SGCR_CRC_POLY = 10'h233;

   // Hash selection encodings
   typedef enum logic [1:0] {
      SGCR_HASH_DIRECT0 = 2'h0,
      SGCR_HASH_CRC     = 2'h1,
      SGCR_HASH_XOR     = 2'h2,
      SGCR_HASH_DIRECT3 = 2'h3
   } sgcr_hash_t;

   // Frame truncation states, Gray ordered
   typedef enum logic [1:0] {
      SGCR_TR_IDLE = 2'b00,
      SGCR_TR_PASS = 2'b01,
      SGCR_TR_DROP = 2'b11
   } sgcr_trunc_t;

endpackage

// >>> sgcr_hash_if.sv
// Request and answer signals between the register bank and the hash unit
`timescale 1ns/1ps
interface sgcr_hash_if;
   import sgcr_pkg::*;

   logic                    req;
   logic [47:0]             dstAddr;
   sgcr_hash_t              sel;
   logic                    done;
   logic [SGCR_INDEX_W-1:0] index;

   modport engine (input req, input dstAddr, input sel, output done, output index);
   modport user   (output req, output dstAddr, output sel, input done, input index);
endinterface

// >>> sgcr_hash_unit.sv
// Dynamic lookup table index generator: direct, CRC or XOR mapping
`timescale 1ns/1ps
module sgcr_hash_unit
   import sgcr_pkg::*;
(
   // Clock, reset, enable
   input  wire logic   clk,
   input  wire logic   rstSyncB,
   input  wire logic   ce,
   // Hash request and answer
   sgcr_hash_if.engine hashBus
);

   // CRC over the 48 address bits, most significant bit first
   function automatic logic [SGCR_INDEX_W-1:0] crcIndex(input logic [47:0] addr);
      logic [SGCR_INDEX_W-1:0] crc;
      logic                    fb;
      crc = '0;
      for (int i = 47; i >= 0; i--) begin
         fb  = crc[SGCR_INDEX_W-1] ^ addr[i];
         crc = {crc[SGCR_INDEX_W-2:0], 1'b0};
         if (fb) begin
            crc = crc ^ SGCR_CRC_POLY;
         end
      end
      return crc;
   endfunction

   // XOR fold of the address into index-wide slices; top slice is 8 bits wide
   function automatic logic [SGCR_INDEX_W-1:0] xorIndex(input logic [47:0] addr);
      logic [SGCR_INDEX_W-1:0] acc;
      acc = addr[9:0] ^ addr[19:10] ^ addr[29:20] ^ addr[39:30];
      acc = acc ^ {2'h0, addr[47:40]};
      return acc;
   endfunction

   logic [SGCR_INDEX_W-1:0] index_q;
   logic                    done_q;

   // Index computed in one cycle, answered in the next
   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         index_q <= '0;
      end else if (ce && hashBus.req) begin
         case (hashBus.sel)
            SGCR_HASH_CRC:     index_q <= crcIndex(hashBus.dstAddr);
            SGCR_HASH_XOR:     index_q <= xorIndex(hashBus.dstAddr);
            default:           index_q <= hashBus.dstAddr[SGCR_INDEX_W-1:0];
         endcase
      end
   end

   // One-cycle answer strobe
   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         done_q <= 1'b0;
      end else if (ce) begin
         done_q <= hashBus.req;
      end
   end

   assign hashBus.index = index_q;
   assign hashBus.done  = done_q;

endmodule // sgcr_hash_unit

// >>> sgcr_global_ctrl_regs.sv
// Global switch control registers: frame length, provider tag, credit and lookup control
`timescale 1ns/1ps
module sgcr_global_ctrl_regs
   import sgcr_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   // Register port
   input  wire logic [11:0] regAddr,
   input  wire logic [15:0] regWrData,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   output logic      [15:0] regRdData,
   // Received payload stream
   input  wire logic        rxValid,
   input  wire logic [7:0]  rxData,
   input  wire logic        rxLast,
   // Forwarded payload stream
   output logic             txValid,
   output logic      [7:0]  txData,
   output logic             txLast,
   output logic             txTruncated,
   // Tag identifier selection
   input  wire logic        tagReq,
   input  wire logic        rxUntagged,
   input  wire logic        doubleTagEn,
   input  wire logic [15:0] rxTagId,
   output logic             tagValid,
   output logic      [15:0] tagIdOut,
   // Credit accounting
   input  wire logic        creditReq,
   input  wire logic [15:0] creditFrameBytes,
   output logic             creditValid,
   output logic      [15:0] shaperDeduct,
   output logic      [15:0] policerDeduct,
   // VLAN classification
   input  wire logic        vidReq,
   input  wire logic        vidInvalid,
   input  wire logic        unknownVidFwdEn,
   output logic             vidValid,
   output logic             vidDrop,
   output logic             vidToHost,
   output logic             vidUnknownFwd,
   output logic             vlanActive,
   // Dynamic entry update and lookup
   input  wire logic        entryUpdate,
   input  wire logic        lookupReq,
   input  wire logic [47:0] lookupDstAddr,
   output logic             entryAgeWrite,
   output logic      [2:0]  entryAgeValue,
   output logic             lookupValid,
   output logic      [9:0]  lookupIndex,
   output logic             rsvdMcastLookupEn
);

   // Byte lane decode: returns 1 when the address hits a register's low or high byte
   function automatic logic hitLow(input logic [11:0] a, input logic [11:0] ofs);
      return a == ofs;
   endfunction

   function automatic logic hitHigh(input logic [11:0] a, input logic [11:0] ofs);
      return a == (ofs + 12'h001);
   endfunction

   // Reset release through two flops; assertion stays asynchronous
   logic rstMeta_q;
   logic rstSyncB;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_q <= 1'b0;
         rstSyncB  <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSyncB  <= rstMeta_q;
      end
   end

   // Stored register contents
   logic [15:0] maxFrameLength_q;
   logic [15:0] providerTagId_q;
   logic [1:0]  shaperStrategy_q;
   logic [7:0]  lookupCtrl0_q;

   logic [13:0] maxPayloadLength;
   logic        vlanEnable;
   logic        dropInvalidVid;
   sgcr_hash_t  lookupHashSelect;

   assign maxPayloadLength = maxFrameLength_q[SGCR_MAX_LEN_MSB:0];
   assign vlanEnable       = lookupCtrl0_q[SGCR_VLAN_EN_BIT];
   assign dropInvalidVid   = lookupCtrl0_q[SGCR_DROP_INVALID_BIT];
   assign lookupHashSelect = sgcr_hash_t'(lookupCtrl0_q[SGCR_HASH_MSB:SGCR_HASH_LSB]);

   // Register writes; a 16-bit write at the base offset fills both bytes
   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         maxFrameLength_q <= SGCR_MAX_FRAME_LENGTH_RST;
         providerTagId_q  <= SGCR_PROVIDER_TAG_RST;
         shaperStrategy_q <= SGCR_SHAPER_STRATEGY_RST[1:0];
         lookupCtrl0_q    <= SGCR_LOOKUP_CTRL0_RST;
      end else if (ce && regWrEn) begin
         if (hitLow(regAddr, SGCR_MAX_FRAME_LENGTH_OFS)) begin
            maxFrameLength_q <= regWrData;
         end
         if (hitHigh(regAddr, SGCR_MAX_FRAME_LENGTH_OFS)) begin
            maxFrameLength_q[15:8] <= regWrData[7:0];
         end
         if (hitLow(regAddr, SGCR_PROVIDER_TAG_OFS)) begin
            providerTagId_q <= regWrData;
         end
         if (hitHigh(regAddr, SGCR_PROVIDER_TAG_OFS)) begin
            providerTagId_q[15:8] <= regWrData[7:0];
         end
         if (hitLow(regAddr, SGCR_SHAPER_STRATEGY_OFS)) begin
            shaperStrategy_q <= regWrData[1:0];
         end
         if (hitLow(regAddr, SGCR_LOOKUP_CTRL0_OFS)) begin
            lookupCtrl0_q <= regWrData[7:0];
         end
      end
   end

   // Read mux; unmapped addresses and the shaper high byte read zero
   logic [15:0] rdMux;

   always_comb begin
      rdMux = 16'h0000;
      if (hitLow(regAddr, SGCR_MAX_FRAME_LENGTH_OFS)) begin
         rdMux = maxFrameLength_q;
      end else if (hitHigh(regAddr, SGCR_MAX_FRAME_LENGTH_OFS)) begin
         rdMux = {8'h00, maxFrameLength_q[15:8]};
      end else if (hitLow(regAddr, SGCR_PROVIDER_TAG_OFS)) begin
         rdMux = providerTagId_q;
      end else if (hitHigh(regAddr, SGCR_PROVIDER_TAG_OFS)) begin
         rdMux = {8'h00, providerTagId_q[15:8]};
      end else if (hitLow(regAddr, SGCR_SHAPER_STRATEGY_OFS)) begin
         rdMux = {14'h0000, shaperStrategy_q};
      end else if (hitLow(regAddr, SGCR_LOOKUP_CTRL0_OFS)) begin
         rdMux = {8'h00, lookupCtrl0_q};
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         regRdData <= 16'h0000;
      end else if (ce) begin
         regRdData <= regRdEn ? rdMux : 16'h0000;
      end
   end

   // Payload truncation: bytes past the limit are swallowed until the frame ends
   sgcr_trunc_t truncState_q;
   logic [13:0] payloadCount_q;
   logic        atLimit;

   // Limit of zero passes nothing; the last allowed byte is forced to end the frame
   assign atLimit = (payloadCount_q + 14'h0001) >= maxPayloadLength;

   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         truncState_q   <= SGCR_TR_IDLE;
         payloadCount_q <= 14'h0000;
      end else if (ce && rxValid) begin
         case (truncState_q)
            SGCR_TR_IDLE, SGCR_TR_PASS: begin
               if (rxLast) begin
                  truncState_q   <= SGCR_TR_IDLE;
                  payloadCount_q <= 14'h0000;
               end else if (atLimit || maxPayloadLength == 14'h0000) begin
                  truncState_q   <= SGCR_TR_DROP;
                  payloadCount_q <= 14'h0000;
               end else begin
                  truncState_q   <= SGCR_TR_PASS;
                  payloadCount_q <= payloadCount_q + 14'h0001;
               end
            end
            SGCR_TR_DROP: begin
               if (rxLast) begin
                  truncState_q <= SGCR_TR_IDLE;
               end
            end
            default: begin
               truncState_q   <= SGCR_TR_IDLE;
               payloadCount_q <= 14'h0000;
            end
         endcase
      end
   end

   // Output stream, registered; truncated frames end early with a flag
   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         txValid     <= 1'b0;
         txData      <= 8'h00;
         txLast      <= 1'b0;
         txTruncated <= 1'b0;
      end else if (ce) begin
         txValid     <= 1'b0;
         txLast      <= 1'b0;
         txTruncated <= 1'b0;
         if (rxValid && truncState_q != SGCR_TR_DROP && maxPayloadLength != 14'h0000) begin
            txValid     <= 1'b1;
            txData      <= rxData;
            txLast      <= rxLast || atLimit;
            txTruncated <= atLimit && !rxLast;
         end
      end
   end

   // Tag identifier: provider value for untagged frames or outer tag when double tagging
   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         tagValid <= 1'b0;
         tagIdOut <= 16'h0000;
      end else if (ce) begin
         tagValid <= tagReq;
         if (tagReq) begin
            tagIdOut <= (rxUntagged || doubleTagEn) ? providerTagId_q : rxTagId;
         end
      end
   end

   // Credit deductions; overhead charged per the accounting bits
   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         creditValid   <= 1'b0;
         shaperDeduct  <= 16'h0000;
         policerDeduct <= 16'h0000;
      end else if (ce) begin
         creditValid <= creditReq;
         if (creditReq) begin
            shaperDeduct  <= shaperStrategy_q[SGCR_SHAPE_ACCT_BIT]
                             ? creditFrameBytes + SGCR_IPG_PREAMBLE_BYTES
                             : creditFrameBytes;
            policerDeduct <= shaperStrategy_q[SGCR_POLICE_ACCT_BIT]
                             ? creditFrameBytes + SGCR_IPG_PREAMBLE_BYTES
                             : creditFrameBytes;
         end
      end
   end

   // VLAN verdict; nothing is dropped or redirected while VLAN mode is off
   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         vidValid      <= 1'b0;
         vidDrop       <= 1'b0;
         vidToHost     <= 1'b0;
         vidUnknownFwd <= 1'b0;
      end else if (ce) begin
         vidValid <= vidReq;
         if (vidReq) begin
            // Unknown-VLAN forwarding takes the frame before the drop bit is considered
            vidUnknownFwd <= vlanEnable && vidInvalid && unknownVidFwdEn;
            vidDrop       <= vlanEnable && vidInvalid && !unknownVidFwdEn
                             && dropInvalidVid;
            vidToHost     <= vlanEnable && vidInvalid && !unknownVidFwdEn
                             && !dropInvalidVid;
         end
      end
   end

   // Static control levels; VLAN enable assumes software already filled the table
   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         vlanActive        <= 1'b0;
         rsvdMcastLookupEn <= 1'b0;
      end else if (ce) begin
         vlanActive        <= vlanEnable;
         rsvdMcastLookupEn <= lookupCtrl0_q[SGCR_RSVD_MCAST_BIT];
      end
   end

   // Age value handed to each dynamic entry update
   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         entryAgeWrite <= 1'b0;
         entryAgeValue <= 3'h0;
      end else if (ce) begin
         entryAgeWrite <= entryUpdate;
         if (entryUpdate) begin
            entryAgeValue <= lookupCtrl0_q[SGCR_AGE_MSB:SGCR_AGE_LSB];
         end
      end
   end

   // Hash unit: one cycle to compute, answer registered here to keep outputs on flops
   sgcr_hash_if hashBus ();

   assign hashBus.req     = ce && lookupReq;
   assign hashBus.dstAddr = lookupDstAddr;
   assign hashBus.sel     = lookupHashSelect;

   sgcr_hash_unit u_hash (
      .clk      (clk),
      .rstSyncB (rstSyncB),
      .ce       (ce),
      .hashBus  (hashBus)
   );

   always_ff @(posedge clk or negedge rstSyncB) begin
      if (!rstSyncB) begin
         lookupValid <= 1'b0;
         lookupIndex <= 10'h000;
      end else if (ce) begin
         lookupValid <= hashBus.done;
         if (hashBus.done) begin
            lookupIndex <= hashBus.index;
         end
      end
   end

endmodule // sgcr_global_ctrl_regs

// >>> sgcr_global_ctrl_regs_sva.sv
// Concurrent checks on the ports of the global switch control register bank
`timescale 1ns/1ps
module sgcr_global_ctrl_regs_sva
   import sgcr_pkg::*;
(
   // Clock, reset, enable
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        ce,
   // Register port
   input wire logic [11:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic        regWrEn,
   input wire logic        regRdEn,
   input wire logic [15:0] regRdData,
   // Forwarded stream
   input wire logic        txValid,
   input wire logic        txLast,
   input wire logic        txTruncated,
   // Credit accounting
   input wire logic        creditReq,
   input wire logic [15:0] creditFrameBytes,
   input wire logic        creditValid,
   input wire logic [15:0] shaperDeduct,
   input wire logic [15:0] policerDeduct,
   // VLAN classification
   input wire logic        vidReq,
   input wire logic        vidInvalid,
   input wire logic        unknownVidFwdEn,
   input wire logic        vidValid,
   input wire logic        vidDrop,
   input wire logic        vidToHost,
   input wire logic        vidUnknownFwd,
   input wire logic        vlanActive,
   // Entry update and lookup
   input wire logic        entryUpdate,
   input wire logic        entryAgeWrite,
   input wire logic        lookupReq,
   input wire logic        lookupValid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Taken strobes, so $past sees plain signals only
   logic rdTaken, rdShaper, wrVlanOn;
   assign rdTaken  = regRdEn && ce;
   assign rdShaper = rdTaken && (regAddr == SGCR_SHAPER_STRATEGY_OFS);
   assign wrVlanOn = regWrEn && ce && (regAddr == SGCR_LOOKUP_CTRL0_OFS) && regWrData[7];

   sequence s_look_req; lookupReq && ce; endsequence
   sequence s_look_ans; ##2 lookupValid; endsequence
   sequence s_upd; entryUpdate && ce; endsequence

   property p_rd_idle; !$past(rdTaken) |-> regRdData == 16'h0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_shaper_rsvd; $past(rdShaper) |-> regRdData[15:2] == 14'h0000; endproperty
   a_shaper_rsvd: assert property (p_shaper_rsvd) else $error("shaper upper bits set");
   property p_trunc_last; txTruncated |-> txValid && txLast; endproperty
   a_trunc_last: assert property (p_trunc_last) else $error("truncation off last byte");
   property p_shaper; creditReq && ce |=> creditValid && (shaperDeduct == $past(creditFrameBytes)
      || shaperDeduct == $past(creditFrameBytes) + 16'h0014); endproperty
   a_shaper: assert property (p_shaper) else $error("shaper deduction wrong");
   property p_police; creditReq && ce |=> creditValid && (policerDeduct == $past(creditFrameBytes)
      || policerDeduct == $past(creditFrameBytes) + 16'h0014); endproperty
   a_police: assert property (p_police) else $error("policer deduction wrong");
   property p_vlan_off; vidReq && ce && !vlanActive
      |=> vidValid && !vidDrop && !vidToHost && !vidUnknownFwd; endproperty
   a_vlan_off: assert property (p_vlan_off) else $error("verdict while vlan off");
   property p_vid_over; vidReq && ce && vlanActive && vidInvalid && unknownVidFwdEn
      |=> vidUnknownFwd && !vidDrop; endproperty
   a_vid_over: assert property (p_vid_over) else $error("unknown forward not taken");
   property p_vlan_rise; $rose(vlanActive) |-> $past(wrVlanOn, 1) || $past(wrVlanOn, 2); endproperty
   a_vlan_rise: assert property (p_vlan_rise) else $error("vlan on without write");
   property p_lookup; s_look_req |-> s_look_ans; endproperty
   a_lookup: assert property (p_lookup) else $error("lookup answer late");
   property p_age; s_upd |=> entryAgeWrite; endproperty
   a_age: assert property (p_age) else $error("age write missing");
endmodule // sgcr_global_ctrl_regs_sva

bind sgcr_global_ctrl_regs sgcr_global_ctrl_regs_sva u_sva (.clk, .rst_b, .ce, .regAddr,
   .regWrData, .regWrEn, .regRdEn, .regRdData, .txValid, .txLast, .txTruncated, .creditReq,
   .creditFrameBytes, .creditValid, .shaperDeduct, .policerDeduct, .vidReq, .vidInvalid,
   .unknownVidFwdEn, .vidValid, .vidDrop, .vidToHost, .vidUnknownFwd, .vlanActive,
   .entryUpdate, .entryAgeWrite, .lookupReq, .lookupValid);

// >>> sgcr_global_ctrl_regs_tb.sv
// Self-checking bench for the global switch control register bank
`timescale 1ns/1ps
module sgcr_global_ctrl_regs_tb;
   import sgcr_pkg::*;
   logic        clk, rst_b, ce, regWrEn, regRdEn, rxValid, rxLast, txValid, txLast;
   logic [11:0] regAddr;
   logic [15:0] regWrData, regRdData, rxTagId, tagIdOut, creditFrameBytes;
   logic [15:0] shaperDeduct, policerDeduct;
   logic [7:0]  rxData, txData;
   logic        txTruncated, tagReq, rxUntagged, doubleTagEn, tagValid, creditReq;
   logic        creditValid, vidReq, vidInvalid, unknownVidFwdEn, vidValid, vidDrop;
   logic        vidToHost, vidUnknownFwd, vlanActive, entryUpdate, lookupReq;
   logic        entryAgeWrite, lookupValid, rsvdMcastLookupEn;
   logic [47:0] lookupDstAddr;
   logic [2:0]  entryAgeValue;
   logic [9:0]  lookupIndex;
   logic [9:0]  txQ[$];
   int          nMismatch, samplesChecked;

   sgcr_global_ctrl_regs dut (.clk, .rst_b, .ce, .regAddr, .regWrData, .regWrEn, .regRdEn,
      .regRdData, .rxValid, .rxData, .rxLast, .txValid, .txData, .txLast, .txTruncated,
      .tagReq, .rxUntagged, .doubleTagEn, .rxTagId, .tagValid, .tagIdOut, .creditReq,
      .creditFrameBytes, .creditValid, .shaperDeduct, .policerDeduct, .vidReq, .vidInvalid,
      .unknownVidFwdEn, .vidValid, .vidDrop, .vidToHost, .vidUnknownFwd, .vlanActive,
      .entryUpdate, .lookupReq, .lookupDstAddr, .entryAgeWrite, .entryAgeValue, .lookupValid,
      .lookupIndex, .rsvdMcastLookupEn);

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Capture forwarded bytes with their end marks
   always @(posedge clk) begin
      if (txValid === 1'b1) txQ.push_back({txTruncated, txLast, txData});
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         nMismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrEn <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, input logic [15:0] e);
      @(posedge clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRdEn <= 1'b0;
      #1 chk(regRdData, e);
   endtask

   task automatic sendFrame(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         rxValid <= 1'b1;
         rxData <= 8'h10 + 8'(i);
         rxLast <= (i == n - 1);
      end
      @(posedge clk);
      rxValid <= 1'b0;
      rxLast <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic vidChk(input logic inv, input logic fwd, input logic [2:0] e);
      @(posedge clk);
      vidReq <= 1'b1;
      vidInvalid <= inv;
      unknownVidFwdEn <= fwd;
      @(posedge clk);
      vidReq <= 1'b0;
      #1 chk({12'h0, vidValid, vidDrop, vidToHost, vidUnknownFwd}, {12'h0, 1'b1, e});
   endtask

   task automatic ageChk(input logic [15:0] ctl, input logic [2:0] age, input logic rsv);
      wr(12'h310, ctl);
      @(posedge clk);
      entryUpdate <= 1'b1;
      @(posedge clk);
      entryUpdate <= 1'b0;
      #1 chk({12'h0, entryAgeWrite, entryAgeValue}, {12'h1, age});
      chk({15'h0, rsvdMcastLookupEn}, {15'h0, rsv});
   endtask

   // Independent model of the index mapping
   function automatic logic [9:0] expIdx(input int h, input logic [47:0] a);
      logic [9:0] c = 10'h000;
      if (h == 1) begin
         for (int i = 47; i >= 0; i--) c = {c[8:0], 1'b0} ^ ((c[9] ^ a[i]) ? 10'h233 : 10'h0);
         return c;
      end
      if (h == 2) return a[9:0] ^ a[19:10] ^ a[29:20] ^ a[39:30] ^ {2'b00, a[47:40]};
      return a[9:0];
   endfunction

   task automatic tRegs;
      rd(12'h308, 16'h07d0);
      rd(12'h30a, 16'h9100);
      rd(12'h30e, 16'h0001);
      rd(12'h310, 16'h0061);
      wr(12'h308, 16'hffff);
      rd(12'h308, 16'hffff);
      wr(12'h308, 16'h2328);
      rd(12'h308, 16'h2328);
      wr(12'h309, 16'h0012);
      rd(12'h308, 16'h1228);
      rd(12'h309, 16'h0012);
      wr(12'h30a, 16'h88a8);
      rd(12'h30a, 16'h88a8);
      rd(12'h30b, 16'h0088);
      wr(12'h30e, 16'hffff);
      wr(12'h30f, 16'h00ff);
      rd(12'h30e, 16'h0003);
      rd(12'h30f, 16'h0000);
      rd(12'h320, 16'h0000);
      @(posedge clk);
      ce <= 1'b0;
      wr(12'h30a, 16'h1234);
      @(posedge clk);
      ce <= 1'b1;
      rd(12'h30a, 16'h88a8);
   endtask

   // Limit of two bytes: longer frame cut, exact frame untouched
   task automatic tTrunc;
      wr(12'h308, 16'h0002);
      txQ.delete();
      sendFrame(4);
      chk(16'(txQ.size()), 16'h2);
      chk({6'h0, txQ[0]}, 16'h0010);
      chk({6'h0, txQ[1]}, 16'h0311);
      txQ.delete();
      sendFrame(2);
      chk({6'h0, txQ[1]}, 16'h0111);
   endtask

   task automatic tCredit;
      for (int s = 0; s < 4; s++) begin
         wr(12'h30e, 16'(s));
         @(posedge clk);
         creditReq <= 1'b1;
         creditFrameBytes <= 16'd1500 + 16'(s);
         @(posedge clk);
         creditReq <= 1'b0;
         #1 chk({15'h0, creditValid}, 16'h1);
         chk(shaperDeduct, 16'd1500 + 16'(s) + (s[1] ? 16'd20 : 16'd0));
         chk(policerDeduct, 16'd1500 + 16'(s) + (s[0] ? 16'd20 : 16'd0));
      end
   endtask

   task automatic tTag;
      for (int c = 0; c < 3; c++) begin
         @(posedge clk);
         tagReq <= 1'b1;
         rxUntagged <= (c == 0);
         doubleTagEn <= (c == 1);
         rxTagId <= 16'h8100;
         @(posedge clk);
         tagReq <= 1'b0;
         #1 chk(tagIdOut, (c == 2) ? 16'h8100 : 16'h88a8);
         chk({15'h0, tagValid}, 16'h1);
      end
   endtask

   task automatic tVid;
      vidChk(1'b1, 1'b0, 3'b000);
      wr(12'h310, 16'h00c1);
      repeat (2) @(posedge clk);
      #1 chk({15'h0, vlanActive}, 16'h1);
      vidChk(1'b1, 1'b0, 3'b100);
      vidChk(1'b1, 1'b1, 3'b001);
      wr(12'h310, 16'h0081);
      vidChk(1'b1, 1'b0, 3'b010);
   endtask

   task automatic tHash;
      for (int h = 0; h < 4; h++) begin
         wr(12'h310, 16'(h));
         @(posedge clk);
         lookupReq <= 1'b1;
         lookupDstAddr <= 48'ha5c3_1e7f_9b42 + 48'(h);
         @(posedge clk);
         lookupReq <= 1'b0;
         @(posedge clk);
         #1 chk({5'h0, lookupValid, lookupIndex}, {6'h1, expIdx(h, 48'ha5c3_1e7f_9b42 + 48'(h))});
      end
   endtask

   task automatic endSim;
      if (nMismatch == 0 && samplesChecked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      nMismatch++;
      endSim;
   end

   initial begin
      rst_b = 1'b0;
      ce = 1'b1;
      {regWrEn, regRdEn, rxValid, rxLast, tagReq, rxUntagged, doubleTagEn} = '0;
      {creditReq, vidReq, vidInvalid, unknownVidFwdEn, entryUpdate, lookupReq} = '0;
      {regAddr, regWrData, rxData, rxTagId, creditFrameBytes, lookupDstAddr} = '0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      tRegs;
      tTrunc;
      tCredit;
      tTag;
      tVid;
      ageChk(16'h002d, 3'b101, 1'b1);
      ageChk(16'h0021, 3'b100, 1'b0);
      tHash;
      // Mid-run reset must bring the defaults back
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rd(12'h30a, 16'h9100);
      rd(12'h310, 16'h0061);
      endSim;
   end
endmodule // sgcr_global_ctrl_regs_tb
